//--- rtl/prhc_pkg.sv
// package: register map, field positions, reset values and carriers of the reference/holdover block
package prhc_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam int unsigned PRHC_IDX_REF_CTRL = 32'h0000001C;  // reference_input_control
   localparam int unsigned PRHC_IDX_HO_CTRL = 32'h0000001D;   // holdover_control
   localparam int unsigned PRHC_IDX_STATUS = 32'h0000001F;    // pll_readback_status
   localparam int unsigned PRHC_IDX_IRQ_STS = 32'h00000020;   // sticky event status
   localparam int unsigned PRHC_IDX_IRQ_MASK = 32'h00000021;  // event mask

   localparam int unsigned PRHC_AW = 12;  // apb address width
   localparam logic [11:0] PRHC_ADDR_REF_CTRL = 12'(PRHC_IDX_REF_CTRL * 4);
   localparam logic [11:0] PRHC_ADDR_HO_CTRL = 12'(PRHC_IDX_HO_CTRL * 4);
   localparam logic [11:0] PRHC_ADDR_STATUS = 12'(PRHC_IDX_STATUS * 4);
   localparam logic [11:0] PRHC_ADDR_IRQ_STS = 12'(PRHC_IDX_IRQ_STS * 4);
   localparam logic [11:0] PRHC_ADDR_IRQ_MASK = 12'(PRHC_IDX_IRQ_MASK * 4);

   // reference_input_control fields
   localparam int unsigned PRHC_REF_DIFF_BIT = 0;  // differential reference mode
   localparam int unsigned PRHC_FIRST_REFERENCE_INPUT_PWR_BIT = 1;  // first reference input power
   localparam int unsigned PRHC_SECOND_REFERENCE_INPUT_PWR_BIT = 2;  // second reference input power
   localparam logic [7:0] PRHC_REF_CTRL_RST = 8'h00;
   localparam logic [7:0] PRHC_REF_CTRL_WMASK = 8'h07;  // writable bits

   // holdover_control fields
   localparam int unsigned PRHC_HO_EN0_BIT = 0;     // holdover enable, first half
   localparam int unsigned PRHC_HO_EXT_BIT = 1;     // external hold pin mode
   localparam int unsigned PRHC_HO_EN2_BIT = 2;     // holdover enable, second half
   localparam int unsigned PRHC_HO_LDCMP_BIT = 3;   // lock detect comparator enable
   localparam int unsigned PRHC_HO_RBDIS_BIT = 4;   // status readback disable
   localparam logic [7:0] PRHC_HO_CTRL_RST = 8'h00;
   localparam logic [7:0] PRHC_HO_CTRL_WMASK = 8'h1F;

   // pll_readback_status fields
   localparam int unsigned PRHC_ST_VCOTH_BIT = 3;  // vco above threshold
   localparam int unsigned PRHC_ST_SECOND_REFERENCE_INPUT_BIT = 4;   // second reference selected
   localparam int unsigned PRHC_ST_HOLD_BIT = 5;   // holdover active
   localparam int unsigned PRHC_ST_CAL_BIT = 6;    // vco calibration finished

   // interrupt event bits
   localparam int unsigned PRHC_EV_W = 4;
   localparam int unsigned PRHC_EV_CAL_BIT = 0;    // calibration finished
   localparam int unsigned PRHC_EV_HOIN_BIT = 1;   // holdover entered
   localparam int unsigned PRHC_EV_HOOUT_BIT = 2;  // holdover left
   localparam int unsigned PRHC_EV_REFSW_BIT = 3;  // selected reference changed
   localparam logic [3:0] PRHC_IRQ_RST = 4'h0;

   // asynchronous pin/analog inputs, before synchronising
   typedef struct packed {
      logic vco_cal_done;     // calibration engine finished
      logic vco_above_thr;    // vco frequency monitor above threshold
      logic second_reference_input_selected;    // switchover logic feeds second reference
      logic ref_valid;        // selected reference present
      logic ld_pin_high;      // lock detect pin comparator raw output
      logic ext_hold_pin;     // external hold request pin
   } prhc_pins_t;

   // control outputs toward the analog front end
   typedef struct packed {
      logic first_reference_input_power_on;
      logic second_reference_input_power_on;
      logic diff_mode;
      logic auto_switch_en;
      logic ld_cmp_en;
   } prhc_ctrl_t;

   // holdover controller states
   typedef enum logic {PRHC_HO_TRACK, PRHC_HO_HOLD} prhc_ho_state_t;

endpackage : prhc_pkg

//--- rtl/prhc_sync.sv
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
`default_nettype none
module prhc_sync
   import prhc_pkg::*;
#(
   parameter int unsigned WIDTH = 6  // bits to synchronise
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // each bit gets its own pair; the first stage is only read by the second
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      logic meta_reg;  // first stage, may go metastable
      logic safe_reg;  // second stage, safe to use
      always_ff @(posedge clock or negedge rst_b)
      begin
         if (!rst_b)
         begin
            meta_reg <= 1'b0;
            safe_reg <= 1'b0;
         end
         else
         begin
            meta_reg <= async_in[i];
            safe_reg <= meta_reg;
         end
      end
      assign sync_out[i] = safe_reg;
   end
endmodule : prhc_sync
`default_nettype wire

//--- rtl/prhc_top.sv
// reference input and holdover control/status block with apb slave and interrupt
// Notes on behaviour
// [RULE1] second reference powered only while bit set
// [RULE2] first reference powered only while bit set
// [RULE3] bit zero picks differential reference mode
// [RULE4] automatic switchover only in single-ended mode
// [RULE5] readback-disable bit hides the status register
// [RULE6] comparator off means lock result reads true
// [RULE7] comparator decides previous lock, routed to monitor
// [RULE8] holdover needs both enable bits set
// [RULE9] software keeps holdover off during calibration
// [RULE10] external mode: hold pin drives holdover state
// [RULE11] status bit six shows calibration finished
// [RULE12] status bit five shows holdover actually active
// [RULE13] status bit four shows selected reference
// [RULE14] status bit three shows vco above threshold
// [RULE15] status register ignores writes, shows live state
`timescale 1ns/1ns
`default_nettype none
module prhc_top
   import prhc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PRHC_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog / pin side
   input wire prhc_pins_t pins,
   output prhc_ctrl_t ctrl,
   output logic holdover_active,
   output logic ld_cmp_monitor,
   output logic irq
);

   // synchronised copies of the pins
   prhc_pins_t pins_s;
   logic [5:0] pins_sync;

   // synchroniser for every asynchronous input
   prhc_sync #(.WIDTH(6)) u_sync
   (
      .clock(clock),
      .rst_b(rst_b),
      .async_in(pins),
      .sync_out(pins_sync)
   );
   assign pins_s = prhc_pins_t'(pins_sync);

   logic [7:0] ref_ctrl_reg;      // reference_input_control
   logic [7:0] ho_ctrl_reg;       // holdover_control
   logic auto_sw_reg;             // switchover permission flop
   logic [3:0] irq_sts_reg;       // sticky events
   logic [3:0] irq_mask_reg;      // event mask, 1 passes
   logic irq_reg;                 // interrupt output flop
   logic ld_mon_reg;              // comparator result to monitor pin
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   prhc_ho_state_t ho_state_reg;  // holdover controller state
   logic cal_prev_reg;            // last calibration flag, for edge
   logic second_reference_input_prev_reg;           // last selected reference, for edge

   // decoded bus phases
   logic setup_ph;   // first cycle of a transfer
   logic access_ok;  // edge at which the transfer completes
   logic wr_en;      // write takes effect at this edge
   assign setup_ph = psel && !penable;
   assign access_ok = psel && penable && pready_reg;
   assign wr_en = access_ok && pwrite;

   // control decode
   logic ho_enable;   // both enable halves set
   logic ho_ext;      // hold pin mode
   logic ld_result;   // previous-lock verdict used by automatic holdover
   logic rb_disable;  // status readback hidden
   assign ho_enable = ho_ctrl_reg[PRHC_HO_EN2_BIT] && ho_ctrl_reg[PRHC_HO_EN0_BIT]; // see [RULE8]
   assign ho_ext = ho_ctrl_reg[PRHC_HO_EXT_BIT];
   // comparator disabled forces the verdict true
   assign ld_result = ho_ctrl_reg[PRHC_HO_LDCMP_BIT] ? pins_s.ld_pin_high : 1'b1; // see [RULE6]
   assign rb_disable = ho_ctrl_reg[PRHC_HO_RBDIS_BIT];

   // live status word, always built from current conditions
   logic [7:0] status_live;
   always_comb
   begin
      status_live = 8'h00;
      status_live[PRHC_ST_CAL_BIT] = pins_s.vco_cal_done;          // see [RULE11]
      status_live[PRHC_ST_HOLD_BIT] = (ho_state_reg == PRHC_HO_HOLD); // see [RULE12]
      status_live[PRHC_ST_SECOND_REFERENCE_INPUT_BIT] = pins_s.second_reference_input_selected;        // see [RULE13]
      status_live[PRHC_ST_VCOTH_BIT] = pins_s.vco_above_thr;       // see [RULE14]
   end

   // address decode for the mapped words
   logic addr_hit;
   always_comb
   begin
      unique case (paddr)
         PRHC_ADDR_REF_CTRL, PRHC_ADDR_HO_CTRL, PRHC_ADDR_STATUS,
         PRHC_ADDR_IRQ_STS, PRHC_ADDR_IRQ_MASK: addr_hit = 1'b1;
         default: addr_hit = 1'b0;  // unmapped answers with an error
      endcase
   end

   // bus handshake: one wait-free access phase, answer flopped in setup
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= setup_ph;
         pslverr_reg <= setup_ph && !addr_hit;
      end
   end

   // read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         prdata_reg <= 32'h00000000;
      else if (setup_ph && !pwrite)
      begin
         unique case (paddr)
            PRHC_ADDR_REF_CTRL: prdata_reg <= {24'h000000, ref_ctrl_reg};
            PRHC_ADDR_HO_CTRL: prdata_reg <= {24'h000000, ho_ctrl_reg};
            // hidden status reads as zero
            PRHC_ADDR_STATUS: prdata_reg <= rb_disable ? 32'h00000000 // see [RULE5]
                                                       : {24'h000000, status_live};
            PRHC_ADDR_IRQ_STS: prdata_reg <= {28'h0000000, irq_sts_reg};
            PRHC_ADDR_IRQ_MASK: prdata_reg <= {28'h0000000, irq_mask_reg};
            default: prdata_reg <= 32'h00000000;
         endcase
      end
      else if (access_ok)
         prdata_reg <= 32'h00000000;  // bus quiet between reads
   end

   // reference control; reserved and switchover bits are not kept here
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ref_ctrl_reg <= PRHC_REF_CTRL_RST;
         auto_sw_reg <= 1'b1;  // single-ended at reset, so switchover allowed
      end
      else if (wr_en && paddr == PRHC_ADDR_REF_CTRL)
      begin
         ref_ctrl_reg <= pwdata[7:0] & PRHC_REF_CTRL_WMASK;        // see [RULE1] [RULE2] [RULE3]
         auto_sw_reg <= !pwdata[PRHC_REF_DIFF_BIT];                 // see [RULE4]
      end
   end

   // holdover control register; status address has no storage at all
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         ho_ctrl_reg <= PRHC_HO_CTRL_RST;
      else if (wr_en && paddr == PRHC_ADDR_HO_CTRL)
         ho_ctrl_reg <= pwdata[7:0] & PRHC_HO_CTRL_WMASK;
      // writes to the status address fall through and are dropped, see [RULE15]
   end

   // holdover controller; calibration safety relies on software, see [RULE9]
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         ho_state_reg <= PRHC_HO_TRACK;
      else if (!ho_enable)
         ho_state_reg <= PRHC_HO_TRACK;  // see [RULE8]
      else if (ho_ext)
         // pin owns the state, automatic path is ignored
         ho_state_reg <= pins_s.ext_hold_pin ? PRHC_HO_HOLD : PRHC_HO_TRACK; // see [RULE10]
      else
      begin
         unique case (ho_state_reg)
            // enter only if the loop was locked before losing reference
            PRHC_HO_TRACK:
               if (!pins_s.ref_valid && ld_result)  // see [RULE7]
                  ho_state_reg <= PRHC_HO_HOLD;
            PRHC_HO_HOLD:
               if (pins_s.ref_valid)
                  ho_state_reg <= PRHC_HO_TRACK;
         endcase
      end
   end

   // comparator result driven to the monitor pin
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         ld_mon_reg <= 1'b0;
      else
         ld_mon_reg <= ho_ctrl_reg[PRHC_HO_LDCMP_BIT] && pins_s.ld_pin_high; // see [RULE7]
   end

   // edge history for events
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cal_prev_reg <= 1'b0;
         second_reference_input_prev_reg <= 1'b0;
      end
      else
      begin
         cal_prev_reg <= pins_s.vco_cal_done;
         second_reference_input_prev_reg <= pins_s.second_reference_input_selected;
      end
   end

   // event pulses
   logic [3:0] ev;
   logic holdover_q;  // holdover output flop, declared ahead of the edge detect that reads it
   always_comb
   begin
      ev = 4'h0;
      ev[PRHC_EV_CAL_BIT] = pins_s.vco_cal_done && !cal_prev_reg;
      ev[PRHC_EV_REFSW_BIT] = pins_s.second_reference_input_selected != second_reference_input_prev_reg;
      ev[PRHC_EV_HOIN_BIT] = status_live[PRHC_ST_HOLD_BIT] && !holdover_q;
      ev[PRHC_EV_HOOUT_BIT] = !status_live[PRHC_ST_HOLD_BIT] && holdover_q;
   end

   // holdover output flop, also last state for edge detect
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         holdover_q <= 1'b0;
      else
         holdover_q <= status_live[PRHC_ST_HOLD_BIT];
   end

   // sticky status: set wins over a write-one clear in the same cycle
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         irq_sts_reg <= PRHC_IRQ_RST;
      else if (wr_en && paddr == PRHC_ADDR_IRQ_STS)
         irq_sts_reg <= (irq_sts_reg & ~pwdata[3:0]) | ev;
      else
         irq_sts_reg <= irq_sts_reg | ev;
   end

   // mask register
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         irq_mask_reg <= PRHC_IRQ_RST;
      else if (wr_en && paddr == PRHC_ADDR_IRQ_MASK)
         irq_mask_reg <= pwdata[3:0];
   end

   // level interrupt, one cycle behind the sticky bits
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(irq_sts_reg & irq_mask_reg);
   end

   // outputs, every one a flop
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign ctrl.first_reference_input_power_on = ref_ctrl_reg[PRHC_FIRST_REFERENCE_INPUT_PWR_BIT];
   assign ctrl.second_reference_input_power_on = ref_ctrl_reg[PRHC_SECOND_REFERENCE_INPUT_PWR_BIT];
   assign ctrl.diff_mode = ref_ctrl_reg[PRHC_REF_DIFF_BIT];
   assign ctrl.auto_switch_en = auto_sw_reg;
   assign ctrl.ld_cmp_en = ho_ctrl_reg[PRHC_HO_LDCMP_BIT];
   assign holdover_active = holdover_q;
   assign ld_cmp_monitor = ld_mon_reg;
   assign irq = irq_reg;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence s_wr_ref;
      wr_en && paddr == PRHC_ADDR_REF_CTRL;
   endsequence
   sequence s_rd_status;
      setup_ph && !pwrite && paddr == PRHC_ADDR_STATUS;
   endsequence

   a_ref_power_follow: assert property (s_wr_ref |=> // see [RULE1] [RULE2] [RULE3]
      ctrl.second_reference_input_power_on == $past(pwdata[2]) && ctrl.first_reference_input_power_on == $past(pwdata[1])
      && ctrl.diff_mode == $past(pwdata[0]))
      else $error("reference control outputs do not follow the write");
   a_auto_switch_mode: assert property (ctrl.auto_switch_en == !ctrl.diff_mode) // see [RULE4]
      else $error("switchover allowed in differential mode");
   a_status_hidden: assert property ((s_rd_status and rb_disable) ##1 access_ok |-> // see [RULE5]
      prdata == 32'h00000000)
      else $error("status visible while readback disabled");
   a_ld_default_true: assert property (!ctrl.ld_cmp_en |-> ld_result) // see [RULE6]
      else $error("disabled comparator not treated as true");
   a_auto_hold_entry: assert property (ho_enable && !ho_ext && !pins_s.ref_valid // see [RULE7]
      && !ld_result && ho_state_reg == PRHC_HO_TRACK |=> ho_state_reg == PRHC_HO_TRACK)
      else $error("holdover entered without previous lock");
   a_hold_needs_enable: assert property (!ho_enable |=> !status_live[PRHC_ST_HOLD_BIT] // see [RULE8]
      ##1 !holdover_active)
      else $error("holdover active while disabled");
   a_ext_hold_pin: assert property (ho_enable && ho_ext |=> // see [RULE10]
      status_live[PRHC_ST_HOLD_BIT] == $past(pins_s.ext_hold_pin))
      else $error("external hold pin not obeyed");
   a_status_live: assert property ( // see [RULE11] [RULE12] [RULE13] [RULE14]
      (s_rd_status and !rb_disable) ##1 access_ok |->
      prdata[6:3] == $past({status_live[6], status_live[5], status_live[4], status_live[3]}))
      else $error("status read does not show live conditions");
   a_status_ro: assert property (wr_en && paddr == PRHC_ADDR_STATUS |=> // see [RULE15]
      $stable(ref_ctrl_reg) && $stable(ho_ctrl_reg) && $stable(irq_mask_reg))
      else $error("write to status register changed state");
   a_set_wins: assert property (wr_en && paddr == PRHC_ADDR_IRQ_STS && ev[0] |=>
      irq_sts_reg[0])
      else $error("event lost against a clear");

endmodule : prhc_top
`default_nettype wire

//--- verif/tb_prhc_top.sv
// self-checking bench for the reference input and holdover control block
`timescale 1ns/1ns
`default_nettype none
module tb_prhc_top
   import prhc_pkg::*;
;
   logic clock, rst_b, psel, penable, pwrite; // clock, reset and apb request
   logic [11:0] paddr; // apb byte address
   logic [31:0] pwdata, prdata; // apb data both ways
   logic pready, pslverr, holdover_active, ld_cmp_monitor, irq; // design outputs
   prhc_pins_t pins; // pin side inputs
   prhc_ctrl_t ctrl; // front end controls
   int errors, checks_done, cyc; // mismatches, comparisons, cycle count
   logic [31:0] rnd; // xorshift state
   logic [33:0] expq[$]; // notes: {is read, error expected, data}
   prhc_pins_t p; // pin pattern being applied
   logic [2:0] v; // reference control value under test
   logic [31:0] sv; // expected status word
   logic [7:0] hv[6] = '{8'h01, 8'h04, 8'h0D, 8'h0D, 8'h00, 8'h05}; // holdover control cases
   logic ldv[6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0}; // lock detect pin per case
   logic hx[6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1}; // expected holdover per case

   prhc_top dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .ctrl(ctrl), .holdover_active(holdover_active),
      .ld_cmp_monitor(ld_cmp_monitor), .irq(irq));

   // free-running 250 MHz clock
   initial
   begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end

   // xorshift step; seeds the random upper data bits and pin patterns
   function automatic logic [31:0] nxt();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction : nxt

   // counts, verdict and stop; the one place the run ends
   task end_sim();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // report one mismatch
   task flag(input string m);
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask : flag

   // level outputs compared against expectation
   task cmp_lvl(input logic [4:0] got, input logic [4:0] exp);
      checks_done++;
      if (got !== exp)
         flag($sformatf("level %h expected %h", got, exp));
   endtask : cmp_lvl

   // apb answer against the oldest note; write data is not compared
   task cmp_rd(input logic [31:0] d, input logic e, input logic [33:0] n);
      checks_done++;
      if (e !== n[32] || (n[33] && d !== n[31:0]))
         flag($sformatf("apb got %h/%b expected %h/%b", d, e, n[31:0], n[32]));
   endtask : cmp_rd

   // one apb transfer: setup, access held until pready, then release
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
      input logic err);
      expq.push_back({~wr, err, exp});
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // register write; random upper bits must be ignored
   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'h1, a, {nxt() & 32'hFFFFFF00} | {24'h0, d}, 32'h0, 1'h0);
   endtask : wr

   // register read with expected word
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0, e, 1'h0);
   endtask : rd

   // pins change right after a rising edge
   task pset(input prhc_pins_t x);
      @(posedge clock);
      pins <= x;
   endtask : pset

   // let n cycles pass, ending mid-cycle where outputs are settled
   task sett(input int n);
      repeat (n) @(negedge clock);
   endtask : sett

   // watcher: every apb answer takes the oldest note
   always @(posedge clock)
   begin
      if (psel && penable && pready === 1'h1)
      begin
         if (expq.size() == 0)
            flag("answer with no request noted");
         else
            cmp_rd(prdata, pslverr, expq.pop_front());
      end
   end

   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         flag("timeout");
         end_sim();
      end
   end

   // main sequence
   initial
   begin
      rst_b = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pins = '0;
      pins.ref_valid = 1'h1;
      p = pins;
      errors = 0;
      checks_done = 0;
      cyc = 0;
      rnd = 32'h538A;
      repeat (5) @(posedge clock);
      rst_b <= 1'h1;
      sett(1);
      cmp_lvl(5'(ctrl), 5'h02);
      cmp_lvl({2'h0, holdover_active, ld_cmp_monitor, irq}, 5'h00);
      rd(PRHC_ADDR_REF_CTRL, 32'h0);
      rd(PRHC_ADDR_HO_CTRL, 32'h0);
      rd(PRHC_ADDR_IRQ_MASK, 32'h0);
      $display("test reset done");
      // every reference control combination, with junk in unused bits
      for (int i = 0; i < 8; i++)
      begin
         v = 3'(i);
         wr(PRHC_ADDR_REF_CTRL, (8'(nxt()) & 8'hF8) | {5'h0, v});
         sett(2);
         cmp_lvl(5'(ctrl), {v[1], v[2], v[0], ~v[0], 1'h0});
         rd(PRHC_ADDR_REF_CTRL, {29'h0, v});
      end
      wr(PRHC_ADDR_REF_CTRL, 8'h00);
      $display("test reference control done");
      // random status pins while holdover stays disabled during calibration
      for (int i = 0; i < 8; i++)
      begin
         sv = nxt();
         p = sv[5:0];
         p.ref_valid = 1'h1;
         p.ext_hold_pin = 1'h0;
         pset(p);
         sett(3);
         sv = {25'h0, p.vco_cal_done, 1'h0, p.second_reference_input_selected, p.vco_above_thr, 3'h0};
         rd(PRHC_ADDR_STATUS, sv);
         cmp_lvl({4'h0, irq}, 5'h00);
      end
      apb(1'h1, PRHC_ADDR_STATUS, nxt(), 32'h0, 1'h0);
      rd(PRHC_ADDR_STATUS, sv);
      wr(PRHC_ADDR_HO_CTRL, 8'h10);
      sett(2);
      rd(PRHC_ADDR_STATUS, 32'h0);
      wr(PRHC_ADDR_HO_CTRL, 8'h00);
      rd(PRHC_ADDR_STATUS, sv);
      $display("test status done");
      // automatic holdover with reference lost, per enable and comparator case
      p = '0;
      for (int k = 0; k < 6; k++)
      begin
         p.ld_pin_high = ldv[k];
         pset(p);
         wr(PRHC_ADDR_HO_CTRL, hv[k]);
         sett(6);
         cmp_lvl({4'h0, holdover_active}, {4'h0, hx[k]});
         cmp_lvl({4'h0, ld_cmp_monitor}, {4'h0, hv[k][3] & ldv[k]});
         cmp_lvl({4'h0, ctrl.ld_cmp_en}, {4'h0, hv[k][3]});
         rd(PRHC_ADDR_STATUS, {26'h0, hx[k], 5'h0});
      end
      p.ref_valid = 1'h1;
      pset(p);
      sett(6);
      cmp_lvl({4'h0, holdover_active}, 5'h00);
      $display("test automatic holdover done");
      // external hold pin mode with the interrupt path
      wr(PRHC_ADDR_IRQ_STS, 8'h0F);
      rd(PRHC_ADDR_IRQ_STS, 32'h0);
      wr(PRHC_ADDR_IRQ_MASK, 8'h02);
      rd(PRHC_ADDR_IRQ_MASK, 32'h2);
      wr(PRHC_ADDR_HO_CTRL, 8'h07);
      sett(6);
      cmp_lvl({4'h0, holdover_active}, 5'h00);
      p.ext_hold_pin = 1'h1;
      pset(p);
      sett(6);
      cmp_lvl({3'h0, holdover_active, irq}, 5'h03);
      rd(PRHC_ADDR_IRQ_STS, 32'h2);
      rd(PRHC_ADDR_STATUS, 32'h20);
      wr(PRHC_ADDR_IRQ_STS, 8'h02);
      sett(3);
      cmp_lvl({4'h0, irq}, 5'h00);
      wr(PRHC_ADDR_IRQ_MASK, 8'h00);
      p.ext_hold_pin = 1'h0;
      pset(p);
      sett(6);
      cmp_lvl({3'h0, holdover_active, irq}, 5'h00);
      rd(PRHC_ADDR_IRQ_STS, 32'h4);
      // calibration finish and reference change also latch events
      p.vco_cal_done = 1'h1;
      p.second_reference_input_selected = 1'h1;
      pset(p);
      sett(4);
      rd(PRHC_ADDR_STATUS, 32'h50);
      rd(PRHC_ADDR_IRQ_STS, 32'hD);
      $display("test external holdover done");
      // unmapped places answer with an error and no data
      apb(1'h0, 12'h078, 32'h0, 32'h0, 1'h1);
      apb(1'h1, 12'h0F0, nxt(), 32'h0, 1'h1);
      apb(1'h0, 12'h100, 32'h0, 32'h0, 1'h1);
      $display("test unmapped done");
      sett(2);
      if (expq.size() != 0)
         flag("apb answers missing");
      end_sim();
   end
endmodule : tb_prhc_top
`default_nettype wire
